// file: hw/cdmc_cache.sv
// Purpose: Configurable direct-mapped cache between core local bus and system bus
// Assumes: Core holds a request until done; system bus returns 4 words in order
// Notes: One-cycle hit answer after the lookup edge; write-through data
//
// Functional notes
// - Whole I, whole D, or split halves
// - Organization set only by supervisor writes
// - Direct mapped, 128 lines of 16 bytes
// - 128-entry tag array, 512x32 data array
// - Tag and data arrays read together
// - Full mode indexes [10:4] and [10:2]
// - Split instruction fetches use index MSB 0
// - Split operand accesses use index MSB 1
// - Hit drives word, completes one cycle
// - Miss starts 16-byte line fetch
// - Fill data gathered in line buffer
// - Operand writes always go to bus
`timescale 1ns/1ps
`include "cdmc_consts.svh"
module cdmc_cache (
  input wire logic core_clk, // Core clock, 125 MHz
  input wire logic rst, // Sync reset, active high
  input wire logic cfg_wr, // Setup register write strobe
  input wire logic cfg_super, // Write comes from supervisor mode
  input wire logic [1:0] cfg_org, // Organization to set
  input wire logic cfg_inv, // Invalidate all lines with the write
  output logic [1:0] cfg_org_out, // Current organization
  input wire logic req_valid, // Core request, held until done
  input wire logic req_ifetch, // Instruction fetch, else operand
  input wire logic req_write, // Operand write
  input wire logic [31:0] req_addr, // Byte address
  input wire logic [31:0] req_wdata, // Write data
  output logic req_done, // Access complete, pulse
  output logic [31:0] req_rdata, // Read data
  output logic sys_req, // System bus request, held until ack
  output logic sys_write, // System bus write
  output logic sys_line, // Line fetch of 4 words
  output logic [31:0] sys_addr, // System bus address
  output logic [31:0] sys_wdata, // System bus write data
  input wire logic sys_ack, // Request taken / write done
  input wire logic sys_rvalid, // Fill word valid
  input wire logic [31:0] sys_rdata // Fill word
);
  import cdmc_pkg::*;
  // *****************************
  // State
  // *****************************
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, // Wait for request
    S_LOOK = 5'b00010, // Arrays being read
    S_FILL = 5'b00100, // Line fetch in progress
    S_WRT = 5'b01000, // Write-through cycle
    S_UPD = 5'b10000 // Copy buffer into arrays
  } cdmc_state_t;
  typedef struct packed {
    cdmc_state_t fsm; // Controller state
    logic [1:0] org; // Setup register organization
    logic done; // Completion pulse
    logic [31:0] rdata; // Read data out
    logic sreq; // Bus request
    logic swr; // Bus write
    logic sline; // Line fetch
    logic [31:0] saddr; // Bus address
    logic [31:0] swdata; // Bus write data
    logic [1:0] upd; // Words copied
    logic inv; // Pending invalidate
  } cdmc_st_t;
  cdmc_st_t st_ff; // Registered state
  cdmc_st_t nxt_st; // Next state
  cdmc_arr_if arr_if (); // Array connection
  logic fb_start; // Start line collection
  logic fb_full; // Line complete
  logic [31:0] fb_word; // Buffer word out
  logic cacheable; // Request belongs to the cache
  logic split; // Split organization
  logic hi_half; // Upper half for operands
  cdmc_line_t line_idx; // Line index
  cdmc_word_t word_idx; // Word index
  logic [20:0] tag_cmp; // Tag to compare
  logic hit; // Lookup hit
  // *****************************
  // Index selection
  // *****************************
  // Split mode gives each stream its half; bit 10 is folded into tag bit 20
  always_comb begin
    split = (st_ff.org == `CDMC_ORG_SPLIT);
    hi_half = !req_ifetch;
    cacheable = (st_ff.org == `CDMC_ORG_ICACHE) ? req_ifetch :
                (st_ff.org == `CDMC_ORG_DCACHE) ? !req_ifetch : 1'b1;
    if (split) begin
      line_idx = {hi_half, req_addr[`CDMC_SPLIT_IDX_MSB:`CDMC_LINE_LSB]};
      word_idx = {hi_half, req_addr[`CDMC_SPLIT_IDX_MSB:`CDMC_WORD_LSB]};
      tag_cmp = req_addr[31:`CDMC_TAG_LSB];
      tag_cmp[20] = tag_cmp[20] ^ req_addr[10];
    end else begin
      line_idx = req_addr[`CDMC_FULL_IDX_MSB:`CDMC_LINE_LSB];
      word_idx = req_addr[`CDMC_FULL_IDX_MSB:`CDMC_WORD_LSB];
      tag_cmp = req_addr[31:`CDMC_TAG_LSB];
    end
  end
  // Split tag folds bit 10 in so addresses in one half that differ only in bit 10 cannot alias
  // Limitation: in split mode bit 10 shares a tag bit with bit 31, so two
  // addresses that differ in exactly those two bits map to one tag
  // Hit only on a valid line with equal tag
  assign hit = arr_if.rd_valid && (arr_if.rd_tag == tag_cmp);
  // *****************************
  // Array drive
  // *****************************
  // Reads always follow the live request so tag and data come together
  always_comb begin
    arr_if.rd_line = line_idx;
    arr_if.rd_word = word_idx;
    arr_if.inv_all = st_ff.inv;
    arr_if.wr_line = line_idx;
    arr_if.wr_tag = tag_cmp;
    arr_if.wr_tag_en = st_ff.fsm == S_UPD && st_ff.upd == 2'h3;
    arr_if.wr_data_en = 1'b0;
    arr_if.wr_word = {line_idx, st_ff.upd};
    arr_if.wr_data = fb_word;
    if (st_ff.fsm == S_UPD) begin
      arr_if.wr_data_en = 1'b1;
    end else if (st_ff.fsm == S_WRT && hit && cacheable) begin
      arr_if.wr_word = word_idx; // Keep a hit line current
      arr_if.wr_data = req_wdata;
      arr_if.wr_data_en = sys_ack;
    end
  end
  // *****************************
  // Controller
  // *****************************
  // One lookup cycle; hit answers on the next edge
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.inv = 1'b0;
    fb_start = 1'b0;
    if (cfg_wr && cfg_super && st_ff.fsm == S_IDLE) begin
      nxt_st.org = cfg_org;
      nxt_st.inv = cfg_inv || (cfg_org != st_ff.org);
    end
    unique case (st_ff.fsm)
      S_IDLE: begin
        // A setup write in this cycle goes first, so no lookup sees old lines
        if (req_valid && !st_ff.done && !st_ff.inv && !nxt_st.inv) begin
          nxt_st.fsm = S_LOOK;
        end
      end
      S_LOOK: begin
        if (req_write) begin
          nxt_st.fsm = S_WRT;
          nxt_st.sreq = 1'b1;
          nxt_st.swr = 1'b1;
          nxt_st.sline = 1'b0;
          nxt_st.saddr = req_addr;
          nxt_st.swdata = req_wdata;
        end else if (hit && cacheable) begin
          nxt_st.rdata = arr_if.rd_data;
          nxt_st.done = 1'b1;
          nxt_st.fsm = S_IDLE;
        end else begin
          nxt_st.fsm = S_FILL;
          nxt_st.sreq = 1'b1;
          nxt_st.swr = 1'b0;
          nxt_st.sline = 1'b1;
          nxt_st.saddr = {req_addr[31:`CDMC_LINE_LSB], 4'h0};
          fb_start = 1'b1;
        end
      end
      S_FILL: begin
        if (sys_ack) begin
          nxt_st.sreq = 1'b0;
        end
        if (fb_full) begin
          nxt_st.upd = 2'h0;
          nxt_st.fsm = cacheable ? S_UPD : S_IDLE;
          nxt_st.rdata = fb_word;
          nxt_st.done = !cacheable;
        end
      end
      S_UPD: begin
        nxt_st.upd = st_ff.upd + 2'h1;
        if (st_ff.upd == req_addr[3:2]) begin
          nxt_st.rdata = fb_word;
        end
        if (st_ff.upd == 2'h3) begin
          nxt_st.done = 1'b1;
          nxt_st.fsm = S_IDLE;
        end
      end
      S_WRT: begin
        if (sys_ack) begin
          nxt_st.sreq = 1'b0;
          nxt_st.done = 1'b1;
          nxt_st.fsm = S_IDLE;
        end
      end
    endcase
    if (rst) begin
      nxt_st = '0;
      nxt_st.fsm = S_IDLE;
      nxt_st.org = `CDMC_ORG_RESET;
      nxt_st.inv = 1'b1;
    end
  end
  // State register
  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end
  // *****************************
  // Submodules
  // *****************************
  cdmc_arrays u_arrays (
    .core_clk(core_clk),
    .rst(rst),
    .arr(arr_if.arr)
  );
  cdmc_fill_buf #(.WORDS(`CDMC_LINE_WORDS)) u_fill (
    .core_clk(core_clk),
    .rst(rst),
    .start(fb_start),
    .in_valid(sys_rvalid && st_ff.fsm == S_FILL),
    .in_data(sys_rdata),
    .full(fb_full),
    .rd_sel(st_ff.fsm == S_UPD ? st_ff.upd : req_addr[3:2]),
    .rd_data(fb_word)
  );
  // *****************************
  // Outputs
  // *****************************
  assign cfg_org_out = st_ff.org;
  assign req_done = st_ff.done;
  assign req_rdata = st_ff.rdata;
  assign sys_req = st_ff.sreq;
  assign sys_write = st_ff.swr;
  assign sys_line = st_ff.sline;
  assign sys_addr = st_ff.saddr;
  assign sys_wdata = st_ff.swdata;
  // *****************************
  // Checks
  // *****************************
  sequence seq_miss_look;
    st_ff.fsm == S_LOOK && !req_write && !(hit && cacheable);
  endsequence
  sequence seq_line_req;
    sys_req && sys_line && !sys_write && sys_addr[3:0] == 4'h0;
  endsequence
  AST_HIT_ONE: assert property (@(posedge core_clk) disable iff (rst)
    st_ff.fsm == S_LOOK && !req_write && hit && cacheable |=> req_done)
    else $error("hit did not complete next cycle");
  AST_MISS_FETCH: assert property (@(posedge core_clk) disable iff (rst)
    seq_miss_look |=> seq_line_req)
    else $error("miss did not start a line fetch");
  AST_WR_THRU: assert property (@(posedge core_clk) disable iff (rst)
    st_ff.fsm == S_LOOK && req_write |=> sys_req && sys_write && sys_addr == $past(req_addr))
    else $error("write not sent to bus");
  AST_USER_CFG: assert property (@(posedge core_clk) disable iff (rst)
    cfg_wr && !cfg_super |=> cfg_org_out == $past(cfg_org_out))
    else $error("user write changed organization");
  AST_SPLIT_I: assert property (@(posedge core_clk) disable iff (rst)
    split && req_ifetch |-> !line_idx[6] && line_idx[5:0] == req_addr[9:4])
    else $error("split fetch index wrong");
  AST_SPLIT_D: assert property (@(posedge core_clk) disable iff (rst)
    split && !req_ifetch |-> line_idx[6] && word_idx[8] && word_idx[7:0] == req_addr[9:2])
    else $error("split operand index wrong");
  AST_FULL_IDX: assert property (@(posedge core_clk) disable iff (rst)
    !split |-> line_idx == req_addr[10:4] && word_idx == req_addr[10:2])
    else $error("full index wrong");
  AST_FILL_DONE: assert property (@(posedge core_clk) disable iff (rst)
    st_ff.fsm == S_UPD && st_ff.upd == 2'h3 |=> req_done && st_ff.fsm == S_IDLE)
    else $error("fill did not finish");
  AST_NO_HIT_INV: assert property (@(posedge core_clk) disable iff (rst)
    st_ff.inv |=> ##1 !arr_if.rd_valid)
    else $error("line still valid after invalidate");
  // Fill hand-over: full buffer starts the copy-in at word zero
  sequence seq_fill_full;
    st_ff.fsm == S_FILL && fb_full && cacheable;
  endsequence
  sequence seq_upd_start;
    st_ff.fsm == S_UPD && st_ff.upd == 2'h0;
  endsequence
  AST_FILL_UPD: assert property (@(posedge core_clk) disable iff (rst)
    seq_fill_full |=> seq_upd_start)
    else $error("full line buffer not copied in");
  // Bus request must not move until the partner takes it
  AST_REQ_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    sys_req && !sys_ack |=> sys_req && $stable(sys_addr) && $stable(sys_write))
    else $error("bus request dropped or changed before ack");
  AST_DONE_PULSE: assert property (@(posedge core_clk) disable iff (rst)
    req_done |=> !req_done)
    else $error("completion held longer than one cycle");
  AST_WR_HIT_UPD: assert property (@(posedge core_clk) disable iff (rst)
    st_ff.fsm == S_WRT && sys_ack && hit && cacheable |-> arr_if.wr_data_en &&
      arr_if.wr_data == req_wdata && arr_if.wr_word == word_idx)
    else $error("write hit did not update the cached word");
  AST_UNCACHED: assert property (@(posedge core_clk) disable iff (rst)
    st_ff.fsm == S_FILL && fb_full && !cacheable |=> req_done && st_ff.fsm == S_IDLE)
    else $error("uncached read did not complete after fill");
  // An organization change must never leave stale lines behind
  AST_ORG_INV: assert property (@(posedge core_clk) disable iff (rst)
    cfg_wr && cfg_super && st_ff.fsm == S_IDLE && cfg_org != cfg_org_out |=> st_ff.inv)
    else $error("organization change did not invalidate");
  AST_SUPER_CFG: assert property (@(posedge core_clk) disable iff (rst)
    cfg_wr && cfg_super && st_ff.fsm == S_IDLE |=> cfg_org_out == $past(cfg_org))
    else $error("supervisor write did not set organization");
endmodule : cdmc_cache

// file: hw/cdmc_consts.svh
// Purpose: Constants for the configurable direct-mapped cache
// Assumes: Included by cdmc_cache, cdmc_arrays and cdmc_fill_buf
// Notes: Geometry, address fields and organization codes only; no logic here
`ifndef CDMC_CONSTS_SVH
`define CDMC_CONSTS_SVH
// Array geometry
`define CDMC_LINES 128
`define CDMC_WORDS 512
`define CDMC_LINE_WORDS 4
// Address fields
`define CDMC_TAG_LSB 11
`define CDMC_FULL_IDX_MSB 10
`define CDMC_SPLIT_IDX_MSB 9
`define CDMC_LINE_LSB 4
`define CDMC_WORD_LSB 2
// Organization codes in the setup register
`define CDMC_ORG_ICACHE 2'h0
`define CDMC_ORG_DCACHE 2'h1
`define CDMC_ORG_SPLIT 2'h2
`define CDMC_ORG_RESET 2'h0
`endif

// file: hw/cdmc_pkg.sv
// Purpose: Shared types for the configurable direct-mapped cache
// Assumes: cdmc_consts.svh sits beside this file
// Notes: Types only; numbers live in the header
package cdmc_pkg;
  // Cache organization
  typedef enum logic [1:0] {
    CDMC_ORG_I = 2'h0,
    CDMC_ORG_D = 2'h1,
    CDMC_ORG_S = 2'h2
  } cdmc_org_t;
  // Line index and word index
  typedef logic [6:0] cdmc_line_t;
  typedef logic [8:0] cdmc_word_t;
endpackage : cdmc_pkg

// file: hw/cdmc_arr_if.sv
// Purpose: Carries lookups and fills between cache control and its arrays
// Assumes: One clock, core_clk
// Notes: Control drives indices and write strobes; arrays answer
`timescale 1ns/1ps
interface cdmc_arr_if;
  import cdmc_pkg::*;
  cdmc_line_t rd_line; // Tag read index
  cdmc_word_t rd_word; // Data read index
  logic [20:0] rd_tag; // Stored tag
  logic rd_valid; // Stored valid bit
  logic [31:0] rd_data; // Stored word
  logic wr_tag_en; // Tag write, sets valid
  logic inv_all; // Clear every valid bit
  cdmc_line_t wr_line; // Tag write index
  logic [20:0] wr_tag; // Tag to store
  logic wr_data_en; // Data word write
  cdmc_word_t wr_word; // Data write index
  logic [31:0] wr_data; // Data to store
  modport ctl (output rd_line, rd_word, wr_tag_en, inv_all, wr_line, wr_tag,
    wr_data_en, wr_word, wr_data, input rd_tag, rd_valid, rd_data);
  modport arr (input rd_line, rd_word, wr_tag_en, inv_all, wr_line, wr_tag,
    wr_data_en, wr_word, wr_data, output rd_tag, rd_valid, rd_data);
endinterface : cdmc_arr_if

// file: hw/cdmc_arrays.sv
// Purpose: Tag array and data array of the cache
// Assumes: Synchronous reads; index presented one cycle before use
// Notes: Both arrays read on the same edge
`timescale 1ns/1ps
`include "cdmc_consts.svh"
module cdmc_arrays (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset, clears valid bits
  cdmc_arr_if.arr arr // Array port
);
  import cdmc_pkg::*;
  // *****************************
  // Storage
  // *****************************
  logic [20:0] tag_mem [`CDMC_LINES]; // Tags per line
  logic [31:0] data_mem [`CDMC_WORDS]; // 512 x 32 words
  typedef struct packed {
    logic [`CDMC_LINES-1:0] valid; // Valid per line
    logic [20:0] tag; // Read tag
    logic vld; // Read valid
    logic [31:0] data; // Read word
  } cdmc_arr_st_t;
  cdmc_arr_st_t st_ff; // Registered state
  cdmc_arr_st_t nxt_st; // Next state
  // *****************************
  // Parallel read
  // *****************************
  // Tag and data read on the same edge
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tag = tag_mem[arr.rd_line];
    nxt_st.vld = st_ff.valid[arr.rd_line];
    nxt_st.data = data_mem[arr.rd_word];
    if (arr.inv_all) begin
      nxt_st.valid = '0;
    end else if (arr.wr_tag_en) begin
      nxt_st.valid[arr.wr_line] = 1'b1;
    end
    if (rst) begin
      nxt_st = '0;
    end
  end
  // State register
  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end
  // Memory writes, no reset needed on contents
  always_ff @(posedge core_clk) begin
    if (arr.wr_tag_en) begin
      tag_mem[arr.wr_line] <= arr.wr_tag;
    end
    if (arr.wr_data_en) begin
      data_mem[arr.wr_word] <= arr.wr_data;
    end
  end
  assign arr.rd_tag = st_ff.tag;
  assign arr.rd_valid = st_ff.vld;
  assign arr.rd_data = st_ff.data;
endmodule : cdmc_arrays

// file: hw/cdmc_fill_buf.sv
// Purpose: 16-byte line fill buffer
// Assumes: Words arrive in line order from offset zero
// Notes: Holds a whole line before it is written to the arrays
`timescale 1ns/1ps
`include "cdmc_consts.svh"
module cdmc_fill_buf #(
  parameter int WORDS = `CDMC_LINE_WORDS // Words per line
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic start, // Begin collecting a line
  input wire logic in_valid, // Fill word present
  input wire logic [31:0] in_data, // Fill word
  output logic full, // Whole line held
  input wire logic [1:0] rd_sel, // Word to read out
  output logic [31:0] rd_data // Selected word
);
  import cdmc_pkg::*;
  // Counter and read select are sized for a four-word line only
  if (WORDS != 4) begin : g_words_chk
    $error("cdmc_fill_buf: line must be 4 words");
  end
  typedef struct packed {
    logic [WORDS-1:0][31:0] word; // Collected words
    logic [2:0] cnt; // Words collected
  } cdmc_fb_st_t;
  cdmc_fb_st_t st_ff; // Registered state
  cdmc_fb_st_t nxt_st; // Next state
  // *****************************
  // Collection
  // *****************************
  // Gather fill words in order
  always_comb begin
    nxt_st = st_ff;
    if (start) begin
      nxt_st.cnt = 3'h0;
    end else if (in_valid && st_ff.cnt != 3'h4) begin
      nxt_st.word[st_ff.cnt[1:0]] = in_data;
      nxt_st.cnt = st_ff.cnt + 3'h1;
    end
    if (rst) begin
      nxt_st = '0;
    end
  end
  // State register
  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end
  assign full = (st_ff.cnt == 3'h4);
  assign rd_data = st_ff.word[rd_sel];
endmodule : cdmc_fill_buf

// file: test/cdmc_sys_mem.sv
// Purpose: System bus partner that answers line fetches and takes writes
// Assumes: One transaction at a time; sys_req held until sys_ack
// Notes: slow adds ack latency and idle gaps between fill words
`timescale 1ns/1ps
module cdmc_sys_mem (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic slow, // Stretch every answer
  input wire logic sys_req, // Request from cache
  input wire logic sys_write, // Write request
  input wire logic sys_line, // Line fetch request
  input wire logic [31:0] sys_addr, // Request address
  input wire logic [31:0] sys_wdata, // Write data
  output logic sys_ack, // Request taken
  output logic sys_rvalid, // Fill word valid
  output logic [31:0] sys_rdata // Fill word
);
  // ******
  // Storage
  // ******
  int n_line; // Line fetches seen
  int n_wr; // Writes seen
  logic [31:0] line_a; // Last line address
  logic [31:0] wr_a; // Last write address
  logic [31:0] wr_d; // Last write data
  // Unwritten words follow a fixed pattern; only the last write is kept
  function automatic logic [31:0] rd(input logic [31:0] a);
    return (n_wr > 0 && a == wr_a) ? wr_d : {a[15:0], ~a[15:0]};
  endfunction : rd
  // ******
  // Answer loop
  // ******
  // Idle data shows the inverse of the last word, except after a slow line fetch, where it ends as the last word itself
  initial begin
    sys_ack = 1'b0;
    sys_rvalid = 1'b0;
    sys_rdata = 32'h0;
    n_line = 0;
    n_wr = 0;
    forever begin
      @(posedge core_clk);
      if (sys_req === 1'b1 && rst === 1'b0) begin
        if (slow) repeat (3) @(posedge core_clk);
        sys_ack <= 1'b1;
        if (sys_write) begin
          n_wr++;
          wr_a = sys_addr;
          wr_d = sys_wdata;
        end
        @(posedge core_clk);
        sys_ack <= 1'b0;
        if (sys_line) begin
          n_line++;
          line_a = sys_addr;
          for (int i = 0; i < 4; i++) begin
            sys_rvalid <= 1'b1;
            sys_rdata <= rd(line_a + 32'(4 * i));
            @(posedge core_clk);
            if (slow) begin
              sys_rvalid <= 1'b0;
              sys_rdata <= ~sys_rdata;
              @(posedge core_clk);
            end
          end
          sys_rvalid <= 1'b0;
          sys_rdata <= ~sys_rdata;
        end
      end
    end
  end
endmodule : cdmc_sys_mem

// file: test/test_configurable_direct_mapped_cache.sv
// Purpose: Self-checking bench for the configurable direct-mapped cache
// Assumes: Partner cdmc_sys_mem on the system bus
// Notes: Hits and misses are told apart by counting line fetches
`timescale 1ns/1ps
`define TB_CHK(nm, exp, got) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); \
  end \
end
module test_configurable_direct_mapped_cache;
  import cdmc_pkg::*;
  // ******
  // Signals
  // ******
  logic core_clk, rst, cfg_wr, cfg_super, cfg_inv; // Clock, reset, setup
  logic [1:0] cfg_org, cfg_org_out; // Organization in and out
  logic req_valid, req_ifetch, req_write, req_done; // Core handshake
  logic [31:0] req_addr, req_wdata, req_rdata; // Core data
  logic sys_req, sys_write, sys_line, sys_ack, sys_rvalid, slow; // System bus
  logic [31:0] sys_addr, sys_wdata, sys_rdata; // System data
  int n_mismatch, cmp_count; // Verdict counters
  cdmc_cache dut_u (.core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_super(cfg_super),
    .cfg_org(cfg_org), .cfg_inv(cfg_inv), .cfg_org_out(cfg_org_out), .req_valid(req_valid),
    .req_ifetch(req_ifetch), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_done(req_done), .req_rdata(req_rdata), .sys_req(sys_req),
    .sys_write(sys_write), .sys_line(sys_line), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
    .sys_ack(sys_ack), .sys_rvalid(sys_rvalid), .sys_rdata(sys_rdata));
  cdmc_sys_mem sys_u (.core_clk(core_clk), .rst(rst), .slow(slow), .sys_req(sys_req),
    .sys_write(sys_write), .sys_line(sys_line), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
    .sys_ack(sys_ack), .sys_rvalid(sys_rvalid), .sys_rdata(sys_rdata));
  // ******
  // Helpers
  // ******
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : pat
  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // Setup write; held one cycle, then settle time for invalidation
  task automatic set_cfg(input logic sup, input logic [1:0] org, input logic inv);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_super <= sup;
    cfg_org <= org;
    cfg_inv <= inv;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : set_cfg
  // One core access; request held until done is seen, then dropped
  task automatic acc(input logic f, input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q, output int n);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_ifetch <= f;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    for (n = 1; n <= 80; n++) begin
      @(posedge core_clk);
      if (req_done === 1'b1) break;
    end
    q = req_rdata;
    req_valid <= 1'b0;
    if (n > 80) begin
      n_mismatch++;
      $display("mismatch req_done expected 1 seen 0");
      conclude();
    end
  endtask : acc
  // Read with expected data and expected hit or miss
  task automatic chk(input string nm, input logic f, input logic [31:0] a,
      input logic [31:0] exp, input logic miss);
    int n0;
    int n;
    logic [31:0] q;
    n0 = sys_u.n_line;
    acc(f, 1'b0, a, 32'h0, q, n);
    `TB_CHK(nm, exp, q)
    `TB_CHK("line fetches", miss ? n0 + 1 : n0, sys_u.n_line)
    if (miss) `TB_CHK("line base", {a[31:4], 4'h0}, sys_u.line_a)
    else `TB_CHK("hit latency", 1'b1, n <= 3)
  endtask : chk
  // ******
  // Scenarios
  // ******
  task automatic t_reset();
    `TB_CHK("org", 2'h0, cfg_org_out)
    `TB_CHK("req_done", 1'b0, req_done)
    `TB_CHK("sys_req", 1'b0, sys_req)
  endtask : t_reset
  // Whole array for fetches; bits 10:4 pick the line
  task automatic t_icache();
    chk("i miss", 1'b1, 32'h1234, pat(32'h1234), 1'b1);
    for (int i = 0; i < 4; i++) begin
      chk("i word", 1'b1, 32'h1230 + 32'(4 * i), pat(32'h1230 + 32'(4 * i)), 1'b0);
    end
    chk("i alias", 1'b1, 32'h1a34, pat(32'h1a34), 1'b1);
    chk("i evicted", 1'b1, 32'h1234, pat(32'h1234), 1'b1);
    chk("i bit10", 1'b1, 32'h1634, pat(32'h1634), 1'b1);
    chk("i kept", 1'b1, 32'h1234, pat(32'h1234), 1'b0);
    chk("op uncached", 1'b0, 32'h2000, pat(32'h2000), 1'b1);
    chk("op uncached", 1'b0, 32'h2000, pat(32'h2000), 1'b1);
  endtask : t_icache
  task automatic t_cfg_user();
    set_cfg(1'b0, 2'h1, 1'b0);
    `TB_CHK("user org", 2'h0, cfg_org_out)
    chk("still held", 1'b1, 32'h1234, pat(32'h1234), 1'b0);
    set_cfg(1'b1, 2'h1, 1'b0);
    `TB_CHK("super org", 2'h1, cfg_org_out)
  endtask : t_cfg_user
  // Data only; writes always reach the bus
  task automatic t_dcache();
    int n0;
    int n;
    logic [31:0] q;
    chk("d miss", 1'b0, 32'h3000, pat(32'h3000), 1'b1);
    chk("d hit", 1'b0, 32'h3000, pat(32'h3000), 1'b0);
    n0 = sys_u.n_wr;
    acc(1'b0, 1'b1, 32'h3000, 32'hdead_beef, q, n);
    `TB_CHK("bus writes", n0 + 1, sys_u.n_wr)
    `TB_CHK("write addr", 32'h3000, sys_u.wr_a)
    `TB_CHK("write data", 32'hdead_beef, sys_u.wr_d)
    chk("d updated", 1'b0, 32'h3000, 32'hdead_beef, 1'b0);
    chk("f uncached", 1'b1, 32'h3000, 32'hdead_beef, 1'b1);
    chk("f uncached", 1'b1, 32'h3000, 32'hdead_beef, 1'b1);
  endtask : t_dcache
  // Split halves with a slow partner
  task automatic t_split();
    slow <= 1'b1;
    set_cfg(1'b1, 2'h2, 1'b0);
    `TB_CHK("split org", 2'h2, cfg_org_out)
    chk("si miss", 1'b1, 32'h4010, pat(32'h4010), 1'b1);
    chk("so miss", 1'b0, 32'h4010, pat(32'h4010), 1'b1);
    chk("si hit", 1'b1, 32'h4010, pat(32'h4010), 1'b0);
    chk("so hit", 1'b0, 32'h4010, pat(32'h4010), 1'b0);
    chk("si alias", 1'b1, 32'h4410, pat(32'h4410), 1'b1);
    chk("si evicted", 1'b1, 32'h4010, pat(32'h4010), 1'b1);
    chk("so kept", 1'b0, 32'h4010, pat(32'h4010), 1'b0);
    set_cfg(1'b1, 2'h2, 1'b1);
    chk("so cleared", 1'b0, 32'h4010, pat(32'h4010), 1'b1);
  endtask : t_split
  // ******
  // Clock and sequence
  // ******
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    {rst, cfg_wr, cfg_super, cfg_inv, cfg_org} = 6'h20;
    {req_valid, req_ifetch, req_write, slow} = 4'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_icache();
    t_cfg_user();
    t_dcache();
    t_split();
    conclude();
  end
endmodule : test_configurable_direct_mapped_cache
